// [core/srq_status_queue.sv]
// status reporting registers, error beeper setting and error queue
// assumes commands arrive already parsed, one per cycle, on clk

// What this block does
// R01: errors leave the queue oldest first.
// R02: each entry holds an eighty character message text.
// R03: queue holds sixteen entries; errors arriving while full are dropped unless a same-cycle pop or clear frees room.
// R04: error query on an empty queue answers code zero, no-error text.
// R05: beeper set on by one, off by zero; query returns one or zero.
// R06: beeper setting lives only in volatile flip-flops.
// R07: enable register is sixteen bits, accepts any value 0 to 65535.
// R08: only bits 0, 1, 9, 11, 12, 13 carry meaning.
// R09: enable write replaces the whole register with the given value.
// R10: enable query returns the present enable contents.
// R11: event register is sixteen bits, query returns its set bits.
// R12: status preset clears the whole enable register.
// R13: clear status zeroes status byte, event register, flushes queue.
// R14: returning an error removes it, freeing one slot.
// R15: reading the event register clears it after returning its value.
module srq_status_queue #(
   parameter int DEPTH = srq_pkg::QUEUE_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // parsed host command
   input wire logic cmd_valid,
   input srq_pkg::srq_cmd_t cmd_code,
   input wire logic [srq_pkg::REG_W-1:0] cmd_arg,
   // newly detected error
   input wire logic err_valid,
   input wire logic [srq_pkg::REG_W-1:0] err_code,
   input wire logic [srq_pkg::TEXT_W-1:0] err_text,
   // questionable-data conditions, one cycle pulses
   input wire logic [srq_pkg::REG_W-1:0] ques_set,
   // answer to queries
   output logic resp_valid,
   output logic [srq_pkg::REG_W-1:0] resp_num,
   output logic [srq_pkg::TEXT_W-1:0] resp_text,
   // state seen by the rest of the instrument
   output logic error_beep_setting,
   output logic beep_pulse,
   output logic err_dropped,
   output logic [srq_pkg::SB_W-1:0] status_byte,
   output logic [srq_pkg::REG_W-1:0] ques_enable
);
   import srq_pkg::*;

   // pointers wrap freely, so depth must be a power of two
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
   localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

   logic rst_meta_ff, rst_sync_ff;
   logic [REG_W-1:0] code_mem_ff [DEPTH];
   logic [TEXT_W-1:0] text_mem_ff [DEPTH];
   logic [PTR_W-1:0] rd_ptr_ff, wr_ptr_ff;
   logic [CNT_W-1:0] count_ff, nxt_count;
   logic beep_ff, beep_pulse_ff, dropped_ff;
   logic [REG_W-1:0] enab_ff, event_ff, nxt_event;
   logic [SB_W-1:0] sb_ff;
   logic resp_valid_ff;
   logic [REG_W-1:0] resp_num_ff;
   logic [TEXT_W-1:0] resp_text_ff;
   logic is_clear, is_pop, is_push, is_even_rd, full;

   // reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   assign is_clear = cmd_valid && cmd_code == SRQ_CMD_CLEAR_STATUS;
   assign is_even_rd = cmd_valid && cmd_code == SRQ_CMD_EVEN_QUERY;
   assign full = count_ff == CNT_FULL;
   // R14: query pops
   assign is_pop = cmd_valid && cmd_code == SRQ_CMD_ERR_QUERY
                   && count_ff != '0;
   // R03: full drops
   assign is_push = err_valid && (!full || is_pop || is_clear);

   // R02: stored text
   always_ff @(posedge clk) begin
      if (is_push) begin
         code_mem_ff[wr_ptr_ff] <= err_code;
         text_mem_ff[wr_ptr_ff] <= err_text;
      end
   end

   always_comb begin
      nxt_count = count_ff;
      if (is_clear) begin
         nxt_count = '0;
      end else if (is_pop) begin
         nxt_count = count_ff - CNT_ONE;
      end
      if (is_push) begin
         nxt_count = nxt_count + CNT_ONE;
      end
   end

   // R01: fifo pointers; R13: flush keeps a same-cycle error
   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         rd_ptr_ff <= '0;
         wr_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         count_ff <= nxt_count;
         if (is_clear) begin
            rd_ptr_ff <= wr_ptr_ff;
         end else if (is_pop) begin
            rd_ptr_ff <= rd_ptr_ff + PTR_ONE;
         end
         if (is_push) begin
            wr_ptr_ff <= wr_ptr_ff + PTR_ONE;
         end
      end
   end

   // R05: beeper set; R06: volatile, reset to off
   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         beep_ff <= 1'b0;
         beep_pulse_ff <= 1'b0;
         dropped_ff <= 1'b0;
      end else begin
         if (cmd_valid && cmd_code == SRQ_CMD_BEEP_SET) begin
            beep_ff <= cmd_arg != BEEP_OFF_VAL;
         end
         beep_pulse_ff <= err_valid && beep_ff;
         dropped_ff <= err_valid && !is_push;
      end
   end

   // R07: full width; R09: replace; R12: preset clears
   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         enab_ff <= QUES_RESET;
      end else if (cmd_valid && cmd_code == SRQ_CMD_ENAB_SET) begin
         enab_ff <= cmd_arg;
      end else if (cmd_valid && cmd_code == SRQ_CMD_PRESET) begin
         enab_ff <= QUES_RESET;
      end
   end

   // R08: used bits only; R15: read clears; new events win
   always_comb begin
      nxt_event = event_ff;
      if (is_even_rd || is_clear) begin
         nxt_event = QUES_RESET;
      end
      nxt_event = nxt_event | (ques_set & QUES_USED_MASK);
   end

   // R11: event latch; R13: status byte cleared
   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         event_ff <= QUES_RESET;
         sb_ff <= SB_RESET;
      end else begin
         event_ff <= nxt_event;
         if (is_clear) begin
            sb_ff <= SB_RESET;
         end else if ((event_ff & enab_ff) != '0) begin
            sb_ff[QUES_SUM_BIT] <= 1'b1;
         end
      end
   end

   // R04: empty answer; R10: enable read; R05: beeper read
   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         resp_valid_ff <= 1'b0;
         resp_num_ff <= '0;
         resp_text_ff <= TEXT_ZERO;
      end else begin
         resp_valid_ff <= 1'b0;
         if (cmd_valid) begin
            resp_text_ff <= TEXT_ZERO;
            case (cmd_code)
               SRQ_CMD_ERR_QUERY: begin
                  resp_valid_ff <= 1'b1;
                  if (count_ff == '0) begin
                     resp_num_ff <= NO_ERR_CODE;
                     resp_text_ff <= NO_ERR_TEXT;
                  end else begin
                     resp_num_ff <= code_mem_ff[rd_ptr_ff];
                     resp_text_ff <= text_mem_ff[rd_ptr_ff];
                  end
               end
               SRQ_CMD_BEEP_QUERY: begin
                  resp_valid_ff <= 1'b1;
                  resp_num_ff <= beep_ff ? BEEP_ON_VAL : BEEP_OFF_VAL;
               end
               SRQ_CMD_ENAB_QUERY: begin
                  resp_valid_ff <= 1'b1;
                  resp_num_ff <= enab_ff;
               end
               SRQ_CMD_EVEN_QUERY: begin
                  resp_valid_ff <= 1'b1;
                  resp_num_ff <= event_ff;
               end
               default: begin
                  resp_valid_ff <= 1'b0;
               end
            endcase
         end
      end
   end

   assign resp_valid = resp_valid_ff;
   assign resp_num = resp_num_ff;
   assign resp_text = resp_text_ff;
   assign error_beep_setting = beep_ff;
   assign beep_pulse = beep_pulse_ff;
   assign err_dropped = dropped_ff;
   assign status_byte = sb_ff;
   assign ques_enable = enab_ff;

   fifo_order_a: assert property (@(posedge clk) // R01
      disable iff (!rst_sync_ff)
      is_pop |=> resp_valid && resp_num == $past(code_mem_ff[rd_ptr_ff]))
      else $error("error returned out of order");
   full_drop_a: assert property (@(posedge clk) // R03
      disable iff (!rst_sync_ff)
      full && err_valid && !is_pop && !is_clear |=> full && err_dropped)
      else $error("error stored into a full queue");
   empty_answer_a: assert property (@(posedge clk) // R04
      disable iff (!rst_sync_ff)
      cmd_valid && cmd_code == SRQ_CMD_ERR_QUERY && count_ff == '0
      |=> resp_valid && resp_num == NO_ERR_CODE && resp_text == NO_ERR_TEXT)
      else $error("empty queue answer wrong");
   beep_query_a: assert property (@(posedge clk) // R05
      disable iff (!rst_sync_ff)
      cmd_valid && cmd_code == SRQ_CMD_BEEP_QUERY
      |=> resp_valid && resp_num == ($past(error_beep_setting)
      ? BEEP_ON_VAL : BEEP_OFF_VAL))
      else $error("beeper query mismatch");
   beep_set_a: assert property (@(posedge clk) // R05
      disable iff (!rst_sync_ff)
      cmd_valid && cmd_code == SRQ_CMD_BEEP_SET
      |=> error_beep_setting == ($past(cmd_arg) != BEEP_OFF_VAL))
      else $error("beeper setting not taken");
   enab_write_a: assert property (@(posedge clk) // R09
      disable iff (!rst_sync_ff)
      cmd_valid && cmd_code == SRQ_CMD_ENAB_SET
      |=> ques_enable == $past(cmd_arg))
      else $error("enable write not whole");
   preset_zero_a: assert property (@(posedge clk) // R12
      disable iff (!rst_sync_ff)
      cmd_valid && cmd_code == SRQ_CMD_PRESET |=> ques_enable == '0)
      else $error("preset left enable bits");
   clear_flush_a: assert property (@(posedge clk) // R13
      disable iff (!rst_sync_ff)
      is_clear && !err_valid && ques_set == '0
      |=> count_ff == '0 && event_ff == '0 && status_byte == '0)
      else $error("clear status incomplete");
   pop_count_a: assert property (@(posedge clk) // R14
      disable iff (!rst_sync_ff)
      is_pop && !err_valid |=> count_ff == $past(count_ff) - CNT_ONE)
      else $error("pop did not free a slot");
   even_clear_a: assert property (@(posedge clk) // R15
      disable iff (!rst_sync_ff)
      is_even_rd && ques_set == '0
      |=> resp_num == $past(event_ff) && event_ff == '0)
      else $error("event read did not clear");
   unused_bits_a: assert property (@(posedge clk) // R08
      disable iff (!rst_sync_ff)
      (event_ff & ~QUES_USED_MASK) == '0)
      else $error("unused event bit set");
endmodule // srq_status_queue

// [core/srq_pkg.sv]
// constants and command codes for the status reporting and error queue block
// assumes a single 100 MHz clock shared with the command decoder upstream
package srq_pkg;
   // queue geometry and text size
   localparam int QUEUE_DEPTH = 16;
   localparam int MSG_CHARS = 80;
   localparam int CHAR_W = 8;
   localparam int TEXT_W = MSG_CHARS * CHAR_W;
   localparam int REG_W = 16;
   localparam int SB_W = 8;
   // meaningful questionable-data bits: 0, 1, 9, 11, 12, 13
   localparam logic [15:0] QUES_USED_MASK = 16'h3a03;
   localparam logic [15:0] QUES_RESET = 16'h0000;
   localparam logic [7:0] SB_RESET = 8'h00;
   // questionable summary position in the status byte
   localparam int QUES_SUM_BIT = 3;
   // answer for an empty queue; first character in the lowest byte
   localparam logic [15:0] NO_ERR_CODE = 16'h0000;
   localparam logic [TEXT_W-1:0] NO_ERR_TEXT = 640'h726f727265206f4e;
   localparam logic [TEXT_W-1:0] TEXT_ZERO = '0;
   // beeper answer values
   localparam logic [15:0] BEEP_ON_VAL = 16'h0001;
   localparam logic [15:0] BEEP_OFF_VAL = 16'h0000;

   typedef enum logic [3:0] {
      SRQ_CMD_NONE,
      SRQ_CMD_ERR_QUERY,
      SRQ_CMD_BEEP_SET,
      SRQ_CMD_BEEP_QUERY,
      SRQ_CMD_ENAB_SET,
      SRQ_CMD_ENAB_QUERY,
      SRQ_CMD_EVEN_QUERY,
      SRQ_CMD_PRESET,
      SRQ_CMD_CLEAR_STATUS
   } srq_cmd_t;
endpackage

// [bench/srq_host_model.sv]
// host model: issues parsed status commands and collects the answers
// assumes commands change on falling clk edges, answer one cycle later
module srq_host_model (
   // clock
   input wire logic clk,
   // command side
   output logic cmd_valid,
   output srq_pkg::srq_cmd_t cmd_code,
   output logic [srq_pkg::REG_W-1:0] cmd_arg,
   // answer side
   input wire logic resp_valid,
   input wire logic [srq_pkg::REG_W-1:0] resp_num,
   input wire logic [srq_pkg::TEXT_W-1:0] resp_text
);
   timeunit 1ns;
   timeprecision 1ps;
   import srq_pkg::*;
   initial begin
      cmd_valid = 1'b0;
      cmd_code = SRQ_CMD_NONE;
      cmd_arg = 16'h0000;
   end
   task automatic send(input srq_cmd_t c, input logic [15:0] a,
         output logic v, output logic [15:0] n, output logic [639:0] t);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_arg = a;
      @(negedge clk);
      // answer stands only in the cycle after the command edge
      v = resp_valid;
      n = resp_num;
      t = resp_text;
      cmd_valid = 1'b0;
      cmd_code = SRQ_CMD_NONE;
      // released argument must not look stable
      cmd_arg = ~a;
   endtask
endmodule // srq_host_model

// [bench/status_reporting_error_queue_test.sv]
// self-checking bench for the status registers and error queue
// assumes host model drives commands; bench drives errors and conditions
module status_reporting_error_queue_test;
   timeunit 1ns;
   timeprecision 1ps;
   import srq_pkg::*;
   logic clk = 1'b0;
   logic rst_n, cmd_valid, err_valid, resp_valid, beep_on, beep_pulse;
   logic err_dropped, v, d, b;
   srq_cmd_t cmd_code;
   logic [15:0] cmd_arg, err_code, ques_set, resp_num, ques_enable, n;
   logic [639:0] err_text, resp_text, t;
   logic [7:0] status_byte;
   int fails = 0;
   int n_tests = 0;
   always #5 clk = ~clk;
   // small depth keeps the overflow case short
   srq_status_queue #(.DEPTH(4)) dut (.clk(clk), .rst_n(rst_n),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
      .err_valid(err_valid), .err_code(err_code), .err_text(err_text),
      .ques_set(ques_set), .resp_valid(resp_valid), .resp_num(resp_num),
      .resp_text(resp_text), .error_beep_setting(beep_on),
      .beep_pulse(beep_pulse), .err_dropped(err_dropped),
      .status_byte(status_byte), .ques_enable(ques_enable));
   srq_host_model host (.clk(clk), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_arg(cmd_arg), .resp_valid(resp_valid),
      .resp_num(resp_num), .resp_text(resp_text));
   task automatic chk(input logic [639:0] s, e);
      n_tests++;
      if (s !== e) begin
         fails++;
         $display("unexpected at %0t: got %0h want %0h", $time, s, e);
      end
   endtask
   task automatic q(input srq_cmd_t c, input logic [15:0] e,
         input logic [639:0] et);
      host.send(c, 16'h0000, v, n, t);
      chk(v, 1'b1);
      chk(n, e);
      chk(t, et);
   endtask
   task automatic s(input srq_cmd_t c, input logic [15:0] a);
      host.send(c, a, v, n, t);
      chk(v, 1'b0);
   endtask
   task automatic err(input logic [15:0] c);
      @(negedge clk);
      err_valid = 1'b1;
      err_code = c;
      err_text = {40{c}};
      @(negedge clk);
      // both flags are one-cycle pulses after the error edge
      d = err_dropped;
      b = beep_pulse;
      err_valid = 1'b0;
      err_code = ~c;
   endtask
   task automatic pulse(input logic [15:0] p);
      @(negedge clk);
      ques_set = p;
      @(negedge clk);
      ques_set = 16'h0000;
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // hang guard, far beyond the whole sequence
   initial begin
      #200000;
      fails++;
      final_report();
   end
   initial begin
      err_valid = 1'b0;
      err_code = 16'h0000;
      err_text = TEXT_ZERO;
      ques_set = 16'h0000;
      do_reset();
      q(SRQ_CMD_ERR_QUERY, NO_ERR_CODE, NO_ERR_TEXT);
      q(SRQ_CMD_BEEP_QUERY, BEEP_OFF_VAL, TEXT_ZERO);
      s(SRQ_CMD_BEEP_SET, 16'h0001);
      chk(beep_on, 1'b1);
      q(SRQ_CMD_BEEP_QUERY, BEEP_ON_VAL, TEXT_ZERO);
      err(16'h00a1);
      chk(b, 1'b1);
      q(SRQ_CMD_ERR_QUERY, 16'h00a1, {40{16'h00a1}});
      s(SRQ_CMD_BEEP_SET, 16'h0000);
      q(SRQ_CMD_BEEP_QUERY, BEEP_OFF_VAL, TEXT_ZERO);
      $display("test beeper done");
      s(SRQ_CMD_ENAB_SET, 16'h0004);
      q(SRQ_CMD_ENAB_QUERY, 16'h0004, TEXT_ZERO);
      s(SRQ_CMD_ENAB_SET, 16'hffff);
      q(SRQ_CMD_ENAB_QUERY, 16'hffff, TEXT_ZERO);
      s(SRQ_CMD_PRESET, 16'h0000);
      chk(ques_enable, QUES_RESET);
      q(SRQ_CMD_ENAB_QUERY, 16'h0000, TEXT_ZERO);
      $display("test enable done");
      pulse(16'hffff);
      q(SRQ_CMD_EVEN_QUERY, QUES_USED_MASK, TEXT_ZERO);
      q(SRQ_CMD_EVEN_QUERY, 16'h0000, TEXT_ZERO);
      $display("test event done");
      // fifth error finds the queue full
      for (int i = 1; i <= 5; i++) begin
         err(16'(i));
         chk(d, i == 5);
         chk(b, 1'b0);
      end
      q(SRQ_CMD_ERR_QUERY, 16'h0001, {40{16'h0001}});
      err(16'h0006);
      chk(d, 1'b0);
      for (int i = 2; i <= 4; i++) begin
         q(SRQ_CMD_ERR_QUERY, 16'(i), {40{16'(i)}});
      end
      q(SRQ_CMD_ERR_QUERY, 16'h0006, {40{16'h0006}});
      q(SRQ_CMD_ERR_QUERY, NO_ERR_CODE, NO_ERR_TEXT);
      $display("test queue done");
      s(SRQ_CMD_ENAB_SET, 16'h0001);
      err(16'h0007);
      pulse(16'h0001);
      q(SRQ_CMD_ENAB_QUERY, 16'h0001, TEXT_ZERO);
      chk(status_byte, 8'(1 << QUES_SUM_BIT));
      s(SRQ_CMD_CLEAR_STATUS, 16'h0000);
      chk(status_byte, SB_RESET);
      q(SRQ_CMD_ERR_QUERY, NO_ERR_CODE, NO_ERR_TEXT);
      q(SRQ_CMD_EVEN_QUERY, 16'h0000, TEXT_ZERO);
      $display("test clear done");
      s(SRQ_CMD_BEEP_SET, 16'h0001);
      do_reset();
      chk(beep_on, 1'b0);
      $display("test volatile done");
      final_report();
   end
endmodule // status_reporting_error_queue_test
